// ### dpll_ctrl.sv
// Register group for one digital loop: history, phase offsets, slew limit, demapping.
`timescale 1ns/1ns
module dpll_ctrl
    import dpll_ctrl_pkg::*;
#(
    parameter int CYCLES_PER_MS = MS_CYCLES
) (
    // Clock and reset.
    input logic pclk,
    input logic presetn,
    // APB slave.
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [15:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Loop tuning words and reference events.
    input logic [29:0] loop_word,
    input logic loop_valid,
    input logic [29:0] free_run_word,
    input logic holdover,
    input logic ref_switch,
    // Holdover history.
    output logic [29:0] holdover_word,
    output logic history_valid,
    output logic history_update,
    // Phase adjustment.
    output logic [29:0] fixed_phase_offset,
    output logic [15:0] phase_step_size,
    output logic [15:0] slew_limit,
    output logic slew_limit_active,
    // Demapping controller.
    output logic demap_enable,
    output logic [15:0] demap_sampled_addr,
    output logic [15:0] demap_setpoint_addr,
    output logic [23:0] demap_gain,
    output logic [7:0] demap_clamp
);
    hist_sched_if s ();

    ms_tick_gen #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .t(s.tick)
    );

    hist_sched u_sched (
        .pclk(pclk),
        .presetn(presetn),
        .s(s.sched)
    );

    // Bus decode.
    logic [7:0] regs [NUM_RW];
    logic [10:0] word_idx;
    logic in_window;
    logic [NUM_RW-1:0] hit_rw;
    logic [NUM_RW-1:0] wr_byte;
    logic hit_status;
    logic mapped;
    logic setup;
    logic wr_go;
    logic err_q;
    logic [7:0] rd_byte;
    logic [7:0] status;

    assign word_idx = paddr[12:2];
    assign in_window = (paddr[1:0] == 2'b00) && (paddr[15:13] == 3'b000);
    assign hit_status = in_window && (word_idx == IDX_STATUS);
    assign mapped = (|hit_rw) || hit_status;
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_q;

    for (genvar i = 0; i < NUM_RW; i++) begin : g_reg
        assign hit_rw[i] = in_window && (word_idx == RW_IDX[i]);
        assign wr_byte[i] = wr_go && hit_rw[i] && pstrb[0];

        // Reserved bits are masked on the way in so they always read zero.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                regs[i] <= RW_RST[i];
            end else if (wr_byte[i]) begin
                regs[i] <= pwdata[7:0] & RW_MASK[i];
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NUM_RW; i++) begin
            if (hit_rw[i]) begin
                rd_byte = regs[i];
            end
        end
        if (hit_status) begin
            rd_byte = status;
        end
    end

    // Read data is captured in the setup phase so the access phase needs no wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata <= {24'h00_0000, rd_byte};
            err_q <= !mapped;
        end
    end

    // Field views.
    logic fallback;
    logic persist;
    logic [2:0] inc_avg;
    logic [15:0] hist_timer;

    assign fallback = regs[P_HISTORY_MODE][HM_FALLBACK_BIT];
    assign persist = regs[P_HISTORY_MODE][HM_PERSIST_BIT];
    assign inc_avg = regs[P_HISTORY_MODE][HM_INC_MSB:0];
    assign hist_timer = {regs[P_TIMER_HI], regs[P_TIMER_LO]};
    assign fixed_phase_offset = {regs[P_FPO_B3][FPO_TOP_MSB:0], regs[P_FPO_B2],
        regs[P_FPO_B1], regs[P_FPO_B0]};
    assign phase_step_size = {regs[P_STEP_HI], regs[P_STEP_LO]};
    assign slew_limit = {regs[P_SLEW_HI], regs[P_SLEW_LO]};
    assign slew_limit_active = (slew_limit != 16'h0000);
    assign demap_enable = regs[P_DEMAP_EN][DEMAP_EN_BIT];
    assign demap_sampled_addr = {regs[P_SAMP_HI], regs[P_SAMP_LO]};
    assign demap_setpoint_addr = {regs[P_SETP_HI], regs[P_SETP_LO]};
    assign demap_gain = {regs[P_GAIN_B2], regs[P_GAIN_B1], regs[P_GAIN_B0]};
    assign demap_clamp = regs[P_CLAMP];

    // History averaging.
    logic [29:0] last_word;
    logic [29:0] history_word;
    logic [45:0] acc_sum;
    logic [15:0] acc_cnt;
    logic [45:0] next_sum;
    logic [15:0] next_cnt;
    logic [45:0] avg_full;
    logic [29:0] next_holdover;
    logic sample;
    logic clear_hist;
    logic slew_low;

    assign clear_hist = ref_switch && !persist;
    assign sample = s.ms_tick && !holdover;
    assign s.restart = clear_hist;
    assign s.frozen = holdover;
    assign s.timer = hist_timer;
    assign s.inc_avg = inc_avg;
    assign history_update = s.hit;

    assign next_sum = (s.full ? 46'h0 : acc_sum) + (sample ? {16'h0000, last_word} : 46'h0);
    assign next_cnt = (s.full ? 16'h0000 : acc_cnt) + (sample ? 16'h0001 : 16'h0000);
    assign avg_full = (acc_cnt == 16'h0000) ? {16'h0000, last_word}
        : acc_sum / {30'h0, acc_cnt};
    assign next_holdover = history_valid ? history_word
        : (fallback ? last_word : free_run_word);

    assign slew_low = slew_limit_active && (slew_limit < SLEW_MIN_USEFUL);
    assign status = {4'h0, holdover, slew_low, s.first_done, history_valid};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_word <= 30'h0;
        end else if (loop_valid) begin
            last_word <= loop_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_sum <= 46'h0;
            acc_cnt <= 16'h0000;
        end else if (clear_hist) begin
            acc_sum <= 46'h0;
            acc_cnt <= 16'h0000;
        end else begin
            acc_sum <= next_sum;
            acc_cnt <= next_cnt;
        end
    end

    // A history update arriving with a reference switch still marks history valid.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            history_word <= 30'h0;
            history_valid <= 1'b0;
        end else if (s.hit) begin
            history_word <= avg_full[29:0];
            history_valid <= 1'b1;
        end else if (clear_hist) begin
            history_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holdover_word <= 30'h0;
        end else begin
            holdover_word <= next_holdover;
        end
    end

    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_free_fallback: assert property (
        !history_valid && !fallback |=> holdover_word == $past(free_run_word))
        else $error("free-run word not used without history");

    chk_last_fallback: assert property (
        !history_valid && fallback |=> holdover_word == $past(last_word))
        else $error("last loop word not used without history");

    chk_history_clear: assert property (
        clear_hist && !s.hit |=> !history_valid && acc_cnt == 16'h0000)
        else $error("history survived a non-persistent switch");

    chk_history_keep: assert property (
        ref_switch && persist && history_valid |=> history_valid)
        else $error("persistent history was lost");

    chk_plain_update: assert property (
        s.hit && inc_avg == 3'h0 |-> s.full)
        else $error("early update with incremental average off");

    chk_late_full: assert property (
        s.hit && $past(s.first_done) && !$past(clear_hist) |-> s.full)
        else $error("early update after first full interval");

    chk_early_needs_n: assert property (
        s.hit && !s.full |-> inc_avg != 3'h0 && !s.first_done)
        else $error("early update without incremental average");

    chk_phase_top: assert property (
        wr_byte[P_FPO_B3] |=> fixed_phase_offset[29:24] == $past(pwdata[5:0]))
        else $error("phase offset top bits wrong");

    chk_step_high: assert property (
        wr_byte[P_STEP_HI] |=> phase_step_size[15:8] == $past(pwdata[7:0]))
        else $error("step size high byte wrong");

    chk_slew_cause: assert property (
        $changed(slew_limit_active) |-> $past(wr_byte[P_SLEW_LO] || wr_byte[P_SLEW_HI]))
        else $error("slew limit changed without a write");

    chk_demap_write: assert property (
        $changed(demap_enable) |-> $past(wr_byte[P_DEMAP_EN]))
        else $error("demap enable changed without a write");

    chk_gain_low: assert property (
        wr_byte[P_GAIN_B0] |=> demap_gain[7:0] == $past(pwdata[7:0]))
        else $error("gain low byte not at lowest address");

    chk_demap_reserved: assert property (
        setup && hit_rw[P_DEMAP_EN] |=> prdata[31:1] == 31'h0)
        else $error("demap reserved bits read nonzero");

    chk_hist_average: assert property (
        s.hit |=> history_word == $past(avg_full[29:0]))
        else $error("history word not the interval average");

    chk_read_back: assert property (
        wr_byte[P_HISTORY_MODE] ##2 setup && hit_rw[P_HISTORY_MODE]
        |=> prdata[7:0] == ($past(pwdata[7:0], 3) & RW_MASK[P_HISTORY_MODE]))
        else $error("history mode readback wrong");

    // Byte lanes other than offset byte 1, the history mode and the timer are checked to land in their field the cycle after their write.
    chk_fpo_low: assert property (
        wr_byte[P_FPO_B0] |=> fixed_phase_offset[7:0] == $past(pwdata[7:0]))
        else $error("offset byte 0 lost");

    chk_fpo_upper: assert property (
        wr_byte[P_FPO_B2] |=> fixed_phase_offset[23:16] == $past(pwdata[7:0]))
        else $error("offset byte 2 lost");

    chk_step_low: assert property (
        wr_byte[P_STEP_LO] |=> phase_step_size[7:0] == $past(pwdata[7:0]))
        else $error("step low byte lost");

    chk_slew_lower: assert property (
        wr_byte[P_SLEW_LO] |=> slew_limit[7:0] == $past(pwdata[7:0]))
        else $error("slew low byte lost");

    chk_slew_upper: assert property (
        wr_byte[P_SLEW_HI] |=> slew_limit[15:8] == $past(pwdata[7:0]))
        else $error("slew high byte lost");

    chk_demap_bit: assert property (
        wr_byte[P_DEMAP_EN] |=> demap_enable == $past(pwdata[0]))
        else $error("demap enable bit lost");

    chk_sampled_low: assert property (
        wr_byte[P_SAMP_LO] |=> demap_sampled_addr[7:0] == $past(pwdata[7:0]))
        else $error("sampled low byte lost");

    chk_sampled_high: assert property (
        wr_byte[P_SAMP_HI] |=> demap_sampled_addr[15:8] == $past(pwdata[7:0]))
        else $error("sampled high byte lost");

    chk_setpoint_low: assert property (
        wr_byte[P_SETP_LO] |=> demap_setpoint_addr[7:0] == $past(pwdata[7:0]))
        else $error("set point low byte lost");

    chk_setpoint_high: assert property (
        wr_byte[P_SETP_HI] |=> demap_setpoint_addr[15:8] == $past(pwdata[7:0]))
        else $error("set point high byte lost");

    chk_gain_mid: assert property (
        wr_byte[P_GAIN_B1] |=> demap_gain[15:8] == $past(pwdata[7:0]))
        else $error("gain middle byte lost");

    chk_gain_top: assert property (
        wr_byte[P_GAIN_B2] |=> demap_gain[23:16] == $past(pwdata[7:0]))
        else $error("gain top byte lost");

    chk_clamp_write: assert property (
        wr_byte[P_CLAMP] |=> demap_clamp == $past(pwdata[7:0]))
        else $error("clamp byte lost");

    chk_error_flag: assert property (
        setup && !mapped ##1 psel && penable |-> pslverr)
        else $error("unmapped access without error");

    cov_persist_keep: cover property (ref_switch && persist && history_valid);
    cov_early_update: cover property (s.hit && !s.full);
    cov_full_update: cover property (s.hit && s.full && !s.first_done);
    cov_switch_clear: cover property (clear_hist && history_valid);
    cov_bus_error: cover property (pslverr);
endmodule

// ### dpll_ctrl_bench.sv
// Self-checking testbench for the digital loop register group.
`timescale 1ns/1ns
module dpll_ctrl_bench
    import dpll_ctrl_pkg::*;
;
    localparam int CPM = 10;
    typedef struct {
        logic [31:0] data;
        logic err;
        bit rd;
    } note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [29:0] loop_word = 30'h0;
    logic loop_valid = 1'b1;
    logic [29:0] free_run_word = 30'h0;
    logic holdover = 1'b0;
    logic ref_switch = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [29:0] holdover_word;
    logic history_valid;
    logic history_update;
    logic [29:0] fixed_phase_offset;
    logic [15:0] phase_step_size;
    logic [15:0] slew_limit;
    logic slew_limit_active;
    logic demap_enable;
    logic [15:0] demap_sampled_addr;
    logic [15:0] demap_setpoint_addr;
    logic [23:0] demap_gain;
    logic [7:0] demap_clamp;
    int errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hc07f97a1;
    logic [31:0] tmp;
    logic [7:0] v [NUM_RW];
    logic [15:0] slews [5] = '{16'h0000, 16'h0032, 16'h0063, 16'h0064, 16'hffff};
    note_t notes [$];
    note_t cur;
    int cnt;

    dpll_ctrl #(.CYCLES_PER_MS(CPM)) dpll_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_word(loop_word), .loop_valid(loop_valid),
        .free_run_word(free_run_word), .holdover(holdover), .ref_switch(ref_switch),
        .holdover_word(holdover_word), .history_valid(history_valid),
        .history_update(history_update), .fixed_phase_offset(fixed_phase_offset),
        .phase_step_size(phase_step_size), .slew_limit(slew_limit),
        .slew_limit_active(slew_limit_active), .demap_enable(demap_enable),
        .demap_sampled_addr(demap_sampled_addr), .demap_setpoint_addr(demap_setpoint_addr),
        .demap_gain(demap_gain), .demap_clamp(demap_clamp)
    );

    always #4 pclk = ~pclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Each completed access takes the oldest note and compares the answer with it.
    always @(posedge pclk) begin
        if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                errors++;
                $display("Error apb_note expected 1 seen 0");
            end else begin
                cur = notes.pop_front();
                check("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
                if (cur.rd) begin
                    check("prdata", cur.data, prdata);
                end
            end
        end
    end

    task automatic apb(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
            input logic [31:0] exp, input logic err);
        note_t n;
        int k;
        n.data = exp;
        n.err = err;
        n.rd = !wr;
        notes.push_back(n);
        @(posedge pclk);
        tmp = xs();
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {tmp[31:8], wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            errors++;
            $display("Error pready expected 1 seen %b", pready);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [10:0] idx, input logic [7:0] d);
        apb(1'b1, {3'h0, idx, 2'h0}, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [10:0] idx, input logic [7:0] e);
        apb(1'b0, {3'h0, idx, 2'h0}, 8'h00, {24'h0, e}, 1'b0);
    endtask

    task automatic reset_dut();
        presetn <= 1'b0;
        ref_switch <= 1'b0;
        holdover <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic pulse_switch();
        @(posedge pclk);
        ref_switch <= 1'b1;
        @(posedge pclk);
        ref_switch <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        reset_dut();
        for (int i = 0; i < NUM_RW; i++) begin
            rd(RW_IDX[i], RW_RST[i]);
        end
        rd(IDX_STATUS, 8'h00);
        check("demap_enable", 32'h0, {31'h0, demap_enable});
        check("demap_gain", 32'h0, {8'h0, demap_gain});
        $display("Test reset values done, errors %0d", errors);
        // Holdover freezes history so the status word is predictable below.
        holdover <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(IDX_SLEW_LO, slews[i][7:0]);
            wr(IDX_SLEW_HI, slews[i][15:8]);
            @(posedge pclk);
            check("slew_limit", {16'h0, slews[i]}, {16'h0, slew_limit});
            check("slew_active", {31'h0, slews[i] != 0}, {31'h0, slew_limit_active});
            rd(IDX_STATUS, {5'h01, slews[i] != 0 && slews[i] < SLEW_MIN_USEFUL, 2'h0});
        end
        $display("Test slew limit done, errors %0d", errors);
        for (int i = 0; i < NUM_RW; i++) begin
            tmp = xs();
            v[i] = tmp[7:0];
            wr(RW_IDX[i], v[i]);
        end
        for (int i = 0; i < NUM_RW; i++) begin
            rd(RW_IDX[i], v[i] & RW_MASK[i]);
        end
        @(posedge pclk);
        check("fixed_phase_offset", {2'h0, v[P_FPO_B3][5:0], v[P_FPO_B2], v[P_FPO_B1],
            v[P_FPO_B0]}, {2'h0, fixed_phase_offset});
        check("step", {16'h0, v[P_STEP_HI], v[P_STEP_LO]}, {16'h0, phase_step_size});
        check("slew", {16'h0, v[P_SLEW_HI], v[P_SLEW_LO]}, {16'h0, slew_limit});
        check("demap_en", {31'h0, v[P_DEMAP_EN][0]}, {31'h0, demap_enable});
        check("sampled", {16'h0, v[P_SAMP_HI], v[P_SAMP_LO]}, {16'h0, demap_sampled_addr});
        check("setpoint", {16'h0, v[P_SETP_HI], v[P_SETP_LO]}, {16'h0, demap_setpoint_addr});
        check("gain", {8'h0, v[P_GAIN_B2], v[P_GAIN_B1], v[P_GAIN_B0]}, {8'h0, demap_gain});
        check("clamp", {24'h0, v[P_CLAMP]}, {24'h0, demap_clamp});
        pstrb <= 4'h0;
        wr(IDX_CLAMP, ~v[P_CLAMP]);
        pstrb <= 4'hf;
        wr(IDX_STATUS, 8'hff);
        apb(1'b1, {3'h0, 11'h41f, 2'h0}, 8'h5a, 32'h0, 1'b1);
        apb(1'b0, {3'h0, 11'h41f, 2'h0}, 8'h00, 32'h0, 1'b1);
        apb(1'b1, {3'h0, IDX_CLAMP, 2'h1}, 8'h5a, 32'h0, 1'b1);
        rd(IDX_CLAMP, v[P_CLAMP]);
        $display("Test register access done, errors %0d", errors);
        for (int n = 0; n < 8; n++) begin
            reset_dut();
            wr(IDX_HISTORY_MODE, n[7:0]);
            cnt = 0;
            repeat (240) begin
                @(posedge pclk);
                if (history_update === 1'b1) begin
                    cnt++;
                end
            end
            check("history_updates", (n >= 3) ? 5 : n + 2, cnt);
        end
        $display("Test history schedule done, errors %0d", errors);
        reset_dut();
        tmp = xs();
        free_run_word <= tmp[29:0];
        tmp = xs();
        loop_word <= tmp[29:0];
        repeat (3) @(posedge pclk);
        check("holdover_word", {2'h0, free_run_word}, {2'h0, holdover_word});
        wr(IDX_HISTORY_MODE, 8'h10);
        repeat (3) @(posedge pclk);
        check("holdover_word", {2'h0, loop_word}, {2'h0, holdover_word});
        cnt = 0;
        while (history_valid !== 1'b1 && cnt < 300) begin
            @(posedge pclk);
            cnt++;
        end
        if (history_valid !== 1'b1) begin
            errors++;
            $display("Error history_valid expected 1 seen %b", history_valid);
        end
        repeat (3) @(posedge pclk);
        check("holdover_avg", {2'h0, loop_word}, {2'h0, holdover_word});
        wr(IDX_HISTORY_MODE, 8'hf8);
        rd(IDX_HISTORY_MODE, 8'h18);
        pulse_switch();
        check("history_kept", 32'h1, {31'h0, history_valid});
        wr(IDX_HISTORY_MODE, 8'h00);
        pulse_switch();
        check("history_cleared", 32'h0, {31'h0, history_valid});
        check("holdover_free", {2'h0, free_run_word}, {2'h0, holdover_word});
        $display("Test holdover history done, errors %0d", errors);
        tally_and_finish();
    end
endmodule

// ### dpll_ctrl_pkg.sv
// Package with register indices, field layouts, reset values and timing counts.
// Behaviour
// - Without history, holdover uses free-run word, or last loop word if fallback set.
// - On reference switch, history clears unless the persistence bit is set; a history update in the same cycle still marks it valid.
// - Incremental-average zero: history updates only after the full interval.
// - Nonzero N: early updates at 1/2^N..1/2 of first interval, then full only.
// - Fixed phase offset is 30-bit signed ps over four bytes, top byte six bits.
// - A 16-bit step size sets the static phase offset step while locked.
// - A 16-bit slew limit caps phase slewing; zero, the reset value, disables it.
// - Bit 0 of the demap control register enables the demap controller.
// - Demap sampled address, set point, gain and clamp are provided, resetting to zero.
// - Multi-byte fields place the least significant byte at the lowest address.
// - Upper seven bits of the demap enable register are reserved and zero.
// - Full history interval comes from a 16-bit ms timer, default 10 ms.
package dpll_ctrl_pkg;
    localparam int NUM_RW = 20;
    localparam int P_HISTORY_MODE = 0;
    localparam int P_FPO_B0 = 1;
    localparam int P_FPO_B1 = 2;
    localparam int P_FPO_B2 = 3;
    localparam int P_FPO_B3 = 4;
    localparam int P_STEP_LO = 5;
    localparam int P_STEP_HI = 6;
    localparam int P_SLEW_LO = 7;
    localparam int P_SLEW_HI = 8;
    localparam int P_DEMAP_EN = 9;
    localparam int P_SAMP_LO = 10;
    localparam int P_SAMP_HI = 11;
    localparam int P_SETP_LO = 12;
    localparam int P_SETP_HI = 13;
    localparam int P_GAIN_B0 = 14;
    localparam int P_GAIN_B1 = 15;
    localparam int P_GAIN_B2 = 16;
    localparam int P_CLAMP = 17;
    localparam int P_TIMER_LO = 18;
    localparam int P_TIMER_HI = 19;
    // Register indices; the byte address is four times the index.
    localparam logic [10:0] IDX_HISTORY_MODE = 11'h40d;
    localparam logic [10:0] IDX_FPO_B0 = 11'h40e;
    localparam logic [10:0] IDX_FPO_B1 = 11'h40f;
    localparam logic [10:0] IDX_FPO_B2 = 11'h410;
    localparam logic [10:0] IDX_FPO_B3 = 11'h411;
    localparam logic [10:0] IDX_STEP_LO = 11'h412;
    localparam logic [10:0] IDX_STEP_HI = 11'h413;
    localparam logic [10:0] IDX_SLEW_LO = 11'h414;
    localparam logic [10:0] IDX_SLEW_HI = 11'h415;
    localparam logic [10:0] IDX_DEMAP_EN = 11'h416;
    localparam logic [10:0] IDX_SAMP_LO = 11'h417;
    localparam logic [10:0] IDX_SAMP_HI = 11'h418;
    localparam logic [10:0] IDX_SETP_LO = 11'h419;
    localparam logic [10:0] IDX_SETP_HI = 11'h41a;
    localparam logic [10:0] IDX_GAIN_B0 = 11'h41b;
    localparam logic [10:0] IDX_GAIN_B1 = 11'h41c;
    localparam logic [10:0] IDX_GAIN_B2 = 11'h41d;
    localparam logic [10:0] IDX_CLAMP = 11'h41e;
    localparam logic [10:0] IDX_TIMER_LO = 11'h420;
    localparam logic [10:0] IDX_TIMER_HI = 11'h421;
    localparam logic [10:0] IDX_STATUS = 11'h422;
    localparam logic [10:0] RW_IDX [NUM_RW] = '{IDX_HISTORY_MODE, IDX_FPO_B0, IDX_FPO_B1,
        IDX_FPO_B2, IDX_FPO_B3, IDX_STEP_LO, IDX_STEP_HI, IDX_SLEW_LO, IDX_SLEW_HI,
        IDX_DEMAP_EN, IDX_SAMP_LO, IDX_SAMP_HI, IDX_SETP_LO, IDX_SETP_HI, IDX_GAIN_B0,
        IDX_GAIN_B1, IDX_GAIN_B2, IDX_CLAMP, IDX_TIMER_LO, IDX_TIMER_HI};
    localparam logic [7:0] RW_MASK [NUM_RW] = '{8'h1f, 8'hff, 8'hff, 8'hff, 8'h3f,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0] RW_RST [NUM_RW] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h0a, 8'h00};
    // Field positions.
    localparam int HM_FALLBACK_BIT = 4;
    localparam int HM_PERSIST_BIT = 3;
    localparam int HM_INC_MSB = 2;
    localparam int FPO_TOP_MSB = 5;
    localparam int DEMAP_EN_BIT = 0;
    localparam int ST_VALID_BIT = 0;
    localparam int ST_FIRST_BIT = 1;
    localparam int ST_SLEW_LOW_BIT = 2;
    localparam int ST_HOLD_BIT = 3;
    localparam logic [15:0] SLEW_MIN_USEFUL = 16'h0064;
    // Timing.
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_IN_NS = 1000000;
    localparam int MS_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
endpackage

// ### hist_sched.sv
// History update scheduler: full-interval and early incremental update points.
`timescale 1ns/1ns
module hist_sched (
    // Clock and reset.
    input logic pclk,
    input logic presetn,
    // Scheduling link.
    hist_sched_if.sched s
);
    logic [15:0] elapsed;
    logic [15:0] next_elapsed;
    logic [6:0] early;
    logic full_now;
    logic early_now;

    assign next_elapsed = elapsed + 16'h0001;
    // A zero timer is undefined; it behaves as a one millisecond interval here.
    assign full_now = s.ms_tick && (next_elapsed >= s.timer);

    for (genvar k = 1; k <= 7; k++) begin : g_early
        logic [15:0] point;
        assign point = s.timer >> k;
        assign early[k-1] = (3'(k) <= s.inc_avg) && (point != 16'h0000)
            && (next_elapsed == point);
    end

    assign early_now = s.ms_tick && !s.first_done && (|early);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed <= 16'h0000;
            s.first_done <= 1'b0;
            s.hit <= 1'b0;
            s.full <= 1'b0;
        end else begin
            s.hit <= !s.restart && (full_now || early_now);
            s.full <= !s.restart && full_now;
            if (s.restart) begin
                elapsed <= 16'h0000;
                s.first_done <= 1'b0;
            end else if (full_now) begin
                elapsed <= 16'h0000;
                s.first_done <= 1'b1;
            end else if (s.ms_tick && !s.frozen) begin
                elapsed <= next_elapsed;
            end
        end
    end
endmodule

// ### hist_sched_if.sv
// Interface joining the millisecond tick, the history scheduler and the register core.
`timescale 1ns/1ns
interface hist_sched_if;
    logic ms_tick;
    logic [15:0] timer;
    logic [2:0] inc_avg;
    logic restart;
    logic frozen;
    logic hit;
    logic full;
    logic first_done;
    modport tick (output ms_tick);
    modport sched (input ms_tick, timer, inc_avg, restart, frozen,
        output hit, full, first_done);
    modport core (input ms_tick, hit, full, first_done,
        output timer, inc_avg, restart, frozen);
endinterface

// ### ms_tick_gen.sv
// Millisecond tick generator from the register clock.
`timescale 1ns/1ns
module ms_tick_gen
    import dpll_ctrl_pkg::*;
#(
    parameter int CYCLES_PER_MS = MS_CYCLES
) (
    // Clock and reset.
    input logic pclk,
    input logic presetn,
    // Tick out.
    hist_sched_if.tick t
);
    localparam int W = $clog2(CYCLES_PER_MS);
    localparam logic [W-1:0] LAST = W'(CYCLES_PER_MS - 1);

    logic [W-1:0] cnt;
    logic wrap;

    if (CYCLES_PER_MS < 2) begin : g_bad_rate
        $error("CYCLES_PER_MS must be at least 2");
    end

    assign wrap = (cnt == LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            t.ms_tick <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : cnt + 1'b1;
            t.ms_tick <= wrap;
        end
    end
endmodule
